// ### acnt_top.v
// 16-bit timer/counter with sync-bypass mode, crystal oscillator
// control, overflow interrupt and wake, on an Avalon-MM slave.
// Assumes all pins are synchronous to mclk; the external count
// clock pin is sampled, optionally through a two-flop synchroniser.
//
// Function
// - Bypass bit counts external clock without synchroniser
// - Bypass mode counts in sleep, overflow wakes
// - Count byte reads always return valid value
// - Write during increment: write wins here
// - Oscillator-enable bit powers crystal oscillator
// - Oscillator keeps running during sleep
// - Crystal oscillator only with internal system clock
// - Oscillator on forces pins 4,5 input
// - Sleep counting only in external bypass mode
// - Overflow wakes; global enable branches to handler
// - Count split into low and high bytes
// - Prescale field divides by 1,2,4,8
// - Gate enable counts only while gate low
// - Source select: external rising edge or mclk/4
`timescale 1ns/1ps
`include "acnt_defs.vh"
module acnt_top
#(
  parameter PS_WIDTH = 3
)
(
  input wire mclk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire ext_count_clock_pin,
  input wire gate_pin,
  input wire sleep_mode,
  input wire sys_clk_internal,
  input wire pin4_direction_in,
  input wire pin5_direction_in,
  input wire port_pin_4_in,
  input wire port_pin_5_in,
  output wire pin4_direction,
  output wire pin5_direction,
  output wire port_pin_4,
  output wire port_pin_5,
  output wire low_power_crystal_osc,
  output wire irq,
  output wire wake_req,
  output wire isr_branch
);

  // Register index from a byte address
  function [7:0] word_index;
    input [9:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  // True when the decoded index selects the given register
  function reg_hit;
    input [7:0] index;
    input [7:0] code;
    begin
      reg_hit = (index == code);
    end
  endfunction

  // Bus answer state
  reg ack_q;
  // Registered read data
  reg [7:0] rdata_q;
  // Control register fields, bit 7 unimplemented
  reg [6:0] ctl_q;
  // Interrupt control register
  reg [7:0] irq_ctl_q;
  // Overflow flag, sticky
  reg ovf_flag_q;
  // Overflow interrupt enable
  reg ovf_ie_q;
  // The 16-bit count; unknown after power-up, never reset
  reg [15:0] count_q;
  // Next count value
  reg [15:0] count_d;
  // Previous count-clock level, for the rising edge
  reg ext_prev_q;
  // Internal clock divider
  reg [1:0] fosc_div_q;

  // Bus strobes and decode
  wire [7:0] idx;
  wire req;
  wire take;
  wire wr_take;
  wire rd_take;
  wire [7:0] wbyte;
  // Derived control fields
  wire cnt_on;
  wire src_ext;
  wire bypass;
  wire osc_req;
  wire [1:0] ps_sel;
  wire gate_en;
  wire osc_on;
  // Count path
  wire ext_synced;
  wire ext_level;
  wire ext_rise;
  wire fosc_tick;
  wire raw_tick;
  wire gate_ok;
  wire sleep_ok;
  wire run;
  wire cnt_tick;
  wire wr_low;
  wire wr_high;
  wire rollover;
  wire ovf_clr;
  // Read multiplexer result
  reg [7:0] rmux;

  assign idx = word_index(avs_address);
  assign req = avs_read | avs_write;
  // One wait cycle, then the answer cycle
  assign avs_waitrequest = req & ~ack_q;
  // Write lands and read completes at the answer edge
  assign take = req & ack_q;
  assign wr_take = avs_write & ack_q;
  assign rd_take = avs_read & ~ack_q;
  assign wbyte = avs_writedata[7:0];
  assign avs_readdata = {24'h000000, rdata_q};

  assign cnt_on = ctl_q[`ACNT_CTL_ON];
  assign src_ext = ctl_q[`ACNT_CTL_SRC];
  assign bypass = ctl_q[`ACNT_CTL_BYPASS];
  assign osc_req = ctl_q[`ACNT_CTL_OSCEN];
  assign ps_sel = ctl_q[`ACNT_CTL_PS_HI:`ACNT_CTL_PS_LO];
  assign gate_en = ctl_q[`ACNT_CTL_GATE];

  // Answer sequencer: waitrequest drops one cycle after a request
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else if (take)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Read mux; unmapped indices and unimplemented bits read zero
  always @*
  begin
    case (idx)
      // All eight bits are plain storage
      `ACNT_IDX_IRQ_CONTROL: rmux = irq_ctl_q;
      // Only the overflow flag is implemented
      `ACNT_IDX_IRQ_FLAGS: rmux = {7'h00, ovf_flag_q};
      // valid read
      // Count lives in mclk domain, so bytes are never torn
      `ACNT_IDX_COUNT_LOW: rmux = count_q[7:0];
      `ACNT_IDX_COUNT_HIGH: rmux = count_q[15:8];
      // Bit 7 unimplemented, reads zero
      `ACNT_IDX_CONTROL: rmux = {1'b0, ctl_q};
      // Only the overflow enable is implemented
      `ACNT_IDX_IRQ_ENABLES: rmux = {7'h00, ovf_ie_q};
      // Unmapped indices read zero
      default: rmux = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle, stands in the answer cycle
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (rd_take)
      rdata_q <= rmux;
  end

  // Control and enable registers, written at the answer edge
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q <= `ACNT_RST_CONTROL;
      irq_ctl_q <= `ACNT_RST_IRQ_CONTROL;
      ovf_ie_q <= `ACNT_RST_ENABLES;
    end
    else if (wr_take)
    begin
      case (idx)
        // Control, bit 7 dropped
        `ACNT_IDX_CONTROL: ctl_q <= wbyte[6:0];
        // Interrupt control, all bits stored
        `ACNT_IDX_IRQ_CONTROL: irq_ctl_q <= wbyte;
        // Only the overflow enable is stored
        `ACNT_IDX_IRQ_ENABLES: ovf_ie_q <= wbyte[`ACNT_OVF_BIT];
        // Count bytes are written elsewhere; others ignored
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  // shared oscillator
  // Crystal oscillator only usable when the system runs internally
  assign osc_on = osc_req & sys_clk_internal;

  // runs in sleep
  // Amplifier enable ignores sleep so the crystal keeps going
  assign low_power_crystal_osc = osc_on;

  // pins 4 and 5 forced
  // Directions read as input and port levels as zero while enabled
  assign pin4_direction = osc_on | pin4_direction_in;
  assign pin5_direction = osc_on | pin5_direction_in;
  assign port_pin_4 = ~osc_on & port_pin_4_in;
  assign port_pin_5 = ~osc_on & port_pin_5_in;

  // Synchronised copy of the external count clock
  acnt_sync2 u_sync
  (
    .mclk (mclk),
    .rst_n (rst_n),
    .din (ext_count_clock_pin),
    .dout (ext_synced)
  );

  // bypass the synchroniser
  // Bypass saves two cycles of latency at the cost of margin
  assign ext_level = bypass ? ext_count_clock_pin : ext_synced;

  // Last level of the selected count-clock path
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ext_prev_q <= 1'b0;
    else
      ext_prev_q <= ext_level;
  end

  // Rising edge of the external clock
  assign ext_rise = ext_level & ~ext_prev_q;

  // Internal instruction clock divider, free running
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fosc_div_q <= 2'h0;
    else
      fosc_div_q <= fosc_div_q + 2'h1;
  end

  // internal clock
  // One tick per four main clocks
  // Compared at full integer width so no bits are dropped
  assign fosc_tick = ({30'h0, fosc_div_q} == (`ACNT_FOSC_DIV - 1));

  assign raw_tick = src_ext ? ext_rise : fosc_tick;

  // gate
  // Gate only acts while the counter is on
  assign gate_ok = ~gate_en | ~gate_pin;

  // runs in sleep
  // Only the unsynchronised external mode survives sleep
  assign sleep_ok = ~sleep_mode | (src_ext & bypass);

  // Counting needs on, an open gate and sleep allowance
  assign run = cnt_on & gate_ok & sleep_ok;

  acnt_prescale #(.WIDTH(PS_WIDTH)) u_ps
  (
    .mclk (mclk),
    .rst_n (rst_n),
    .clear (~cnt_on),
    .tick_in (raw_tick & run),
    .sel (ps_sel),
    .tick_out (cnt_tick)
  );

  // Count byte writes, taken at the answer edge
  assign wr_low = wr_take & reg_hit(idx, `ACNT_IDX_COUNT_LOW);
  assign wr_high = wr_take & reg_hit(idx, `ACNT_IDX_COUNT_HIGH);
  // A write in the same cycle cancels the increment, so no rollover
  assign rollover = cnt_tick & (count_q == 16'hFFFF) & ~wr_low & ~wr_high;

  // write contention
  // A byte write wins over an increment in the same cycle;
  // the other byte keeps its old value, so results may look odd
  always @*
  begin
    // Default: hold
    count_d = count_q;
    if (wr_low)
      // Low byte replaced, high byte kept
      count_d = {count_q[15:8], wbyte};
    else if (wr_high)
      // High byte replaced, low byte kept
      count_d = {wbyte, count_q[7:0]};
    else if (cnt_tick)
      // Increment wraps to zero after all ones
      count_d = count_q + 16'h0001;
  end

  // Count register; no reset, its power-up value is unknown
  always @(posedge mclk)
  begin
    count_q <= count_d;
  end

  // Flag clears on a read of its register
  assign ovf_clr = avs_read & take & reg_hit(idx, `ACNT_IDX_IRQ_FLAGS);

  // overflow flag
  // Set wins over the read clear, so an overflow in the answer cycle is kept
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ovf_flag_q <= `ACNT_RST_FLAGS;
    else if (rollover)
      ovf_flag_q <= 1'b1;
    else if (ovf_clr)
      ovf_flag_q <= 1'b0;
  end

  // Unmasked flag drives the level interrupt
  assign irq = ovf_flag_q & ovf_ie_q;

  // wake and branch
  // Wake needs the peripheral enable; branch also needs global
  assign wake_req = irq & irq_ctl_q[`ACNT_IRQ_PERIPHERAL_IRQ_ENABLE];
  assign isr_branch = wake_req & irq_ctl_q[`ACNT_IRQ_GIE];

endmodule // acnt_top

// ### acnt_defs.vh
// Constants for the asynchronous-capable 16-bit counter block.
// Assumes inclusion by bare name; definitions only.
`ifndef ACNT_DEFS_VH
`define ACNT_DEFS_VH

// Register indices; byte address is four times the index
`define ACNT_IDX_IRQ_CONTROL 8'h0B
`define ACNT_IDX_IRQ_FLAGS 8'h0C
`define ACNT_IDX_COUNT_LOW 8'h0E
`define ACNT_IDX_COUNT_HIGH 8'h0F
`define ACNT_IDX_CONTROL 8'h10
`define ACNT_IDX_IRQ_ENABLES 8'h8C

// Counter control field positions
`define ACNT_CTL_ON 0
`define ACNT_CTL_SRC 1
`define ACNT_CTL_BYPASS 2
`define ACNT_CTL_OSCEN 3
`define ACNT_CTL_PS_LO 4
`define ACNT_CTL_PS_HI 5
`define ACNT_CTL_GATE 6

// Interrupt control and flag positions
`define ACNT_IRQ_GIE 7
`define ACNT_IRQ_PERIPHERAL_IRQ_ENABLE 6
`define ACNT_OVF_BIT 0

// Reset values
`define ACNT_RST_CONTROL 7'h00
`define ACNT_RST_IRQ_CONTROL 8'h00
`define ACNT_RST_FLAGS 1'h0
`define ACNT_RST_ENABLES 1'h0

// Internal instruction clock is the main clock divided by this
`define ACNT_FOSC_DIV 4

`endif

// ### acnt_sync2.v
// Two-flop synchroniser for one level signal.
// Assumes the input may change at any time relative to mclk.
`timescale 1ns/1ps
module acnt_sync2
(
  input wire mclk,
  input wire rst_n,
  input wire din,
  output wire dout
);

  // First stage, read only by the second stage
  reg meta_q;
  // Second stage, safe to use
  reg sync_q;

  // Shift the level through two stages
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // acnt_sync2

// ### acnt_prescale.v
// Count-clock prescaler: passes one tick out of 1, 2, 4 or 8.
// Assumes tick_in is a one-cycle pulse in the mclk domain.
`timescale 1ns/1ps
module acnt_prescale
#(
  parameter WIDTH = 3
)
(
  input wire mclk,
  input wire rst_n,
  input wire clear,
  input wire tick_in,
  input wire [1:0] sel,
  output wire tick_out
);

  // Prescale counter
  reg [WIDTH-1:0] div_q;
  // Mask of bits that must be all ones for a pass
  reg [WIDTH-1:0] mask;

  // Ratio select: 00 1:1, 01 1:2, 10 1:4, 11 1:8
  always @*
  begin
    case (sel)
      2'b00: mask = {WIDTH{1'b0}};
      2'b01: mask = {{(WIDTH-1){1'b0}}, 1'b1};
      2'b10: mask = {{(WIDTH-2){1'b0}}, 2'b11};
      default: mask = {WIDTH{1'b1}};
    endcase
  end

  // Advance on each input tick; cleared when the counter stops
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= {WIDTH{1'b0}};
    else if (clear)
      div_q <= {WIDTH{1'b0}};
    else if (tick_in)
      div_q <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  assign tick_out = tick_in && ((div_q & mask) == mask);

endmodule // acnt_prescale

// ### acnt_chk.sv
// Port checker for the counter block, bound into acnt_top.
// Assumes one mclk domain and rst_n asynchronous, active low.
`timescale 1ns/1ps
module acnt_chk
#(
  parameter PS_WIDTH = 3
)
(
  input wire mclk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire sys_clk_internal,
  input wire pin4_direction_in,
  input wire port_pin_4_in,
  input wire pin4_direction,
  input wire pin5_direction,
  input wire port_pin_4,
  input wire port_pin_5,
  input wire low_power_crystal_osc,
  input wire irq,
  input wire wake_req,
  input wire isr_branch
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A new request waits exactly one cycle
  property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait not one cycle");
  property p_rdhi; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
  property p_unmap; avs_read && !avs_waitrequest && avs_address[9:2] == 8'h20
    |-> avs_readdata == 32'h00000000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dir; low_power_crystal_osc |-> pin4_direction && pin5_direction; endproperty
  a_dir: assert property (p_dir) else $error("direction not forced");
  property p_port; low_power_crystal_osc |-> !port_pin_4 && !port_pin_5; endproperty
  a_port: assert property (p_port) else $error("port pins not zero");
  property p_pass; !low_power_crystal_osc |-> pin4_direction == pin4_direction_in
    && port_pin_4 == port_pin_4_in; endproperty
  a_pass: assert property (p_pass) else $error("pins not passed through");
  property p_osc; low_power_crystal_osc |-> sys_clk_internal; endproperty
  a_osc: assert property (p_osc) else $error("oscillator on with external clock");
  property p_wake; wake_req |-> irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  property p_isr; isr_branch |-> wake_req; endproperty
  a_isr: assert property (p_isr) else $error("branch without wake");
  // Sticky flag: irq only drops after a bus access
  property p_fall; $fell(irq) |-> $past(avs_read || avs_write); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped on its own");
endmodule // acnt_chk
bind acnt_top acnt_chk #(.PS_WIDTH(PS_WIDTH)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sys_clk_internal(sys_clk_internal), .pin4_direction_in(pin4_direction_in),
  .port_pin_4_in(port_pin_4_in), .pin4_direction(pin4_direction),
  .pin5_direction(pin5_direction), .port_pin_4(port_pin_4), .port_pin_5(port_pin_5),
  .low_power_crystal_osc(low_power_crystal_osc), .irq(irq), .wake_req(wake_req),
  .isr_branch(isr_branch));

// ### acnt_src_model.sv
// External count clock source in place of the crystal.
// Assumes pins are mclk-synchronous; stands low while not running.
`timescale 1ns/1ps
module acnt_src_model
(
  input wire mclk,
  input wire run,
  output reg clk_out
);
  reg div_q = 1'b0; // Half-period phase
  initial clk_out = 1'b0;
  // A started high phase ends cleanly, so no stray edge after stop
  always @(posedge mclk)
  begin
    if (run || clk_out)
    begin
      div_q <= ~div_q;
      if (div_q)
        clk_out <= ~clk_out;
    end
  end
endmodule // acnt_src_model

// ### tb_async_counter_with_lp_osc.sv
// Self-checking bench for acnt_top with an external count source.
// Assumes the Avalon slave answers with waitrequest; count has no reset.
`timescale 1ns/1ps
`include "acnt_defs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_async_counter_with_lp_osc;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg [9:0] avs_address = 10'h000;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg gate_pin = 1'b0;
  reg sleep_mode = 1'b0;
  reg sys_clk_internal = 1'b0;
  reg [3:0] pin_in = 4'h0; // Port logic: dir4, dir5, level4, level5
  reg src_run = 1'b0;
  reg pin_d = 1'b0;
  reg [7:0] rd;
  int error_cnt = 0;
  int compares = 0;
  int edge_cnt = 0; // Rising edges seen on the count pin
  wire [31:0] avs_readdata;
  wire avs_waitrequest, ext_count_clock_pin, pin4_direction, pin5_direction;
  wire port_pin_4, port_pin_5, low_power_crystal_osc, irq, wake_req, isr_branch;
  acnt_top dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_count_clock_pin(ext_count_clock_pin), .gate_pin(gate_pin), .sleep_mode(sleep_mode),
    .sys_clk_internal(sys_clk_internal), .pin4_direction_in(pin_in[3]),
    .pin5_direction_in(pin_in[2]), .port_pin_4_in(pin_in[1]), .port_pin_5_in(pin_in[0]),
    .pin4_direction(pin4_direction), .pin5_direction(pin5_direction),
    .port_pin_4(port_pin_4), .port_pin_5(port_pin_5),
    .low_power_crystal_osc(low_power_crystal_osc), .irq(irq), .wake_req(wake_req),
    .isr_branch(isr_branch));
  acnt_src_model src (.mclk(mclk), .run(src_run), .clk_out(ext_count_clock_pin));
  // Clock, 10 ns period
  initial forever #5 mclk = ~mclk;
  // Count source edges independently of the design
  always @(posedge mclk)
  begin
    pin_d <= ext_count_clock_pin;
    if (ext_count_clock_pin && !pin_d)
      edge_cnt <= edge_cnt + 1;
  end
  // One Avalon transfer; holds until waitrequest is sampled low
  task bus(input bit wr, input [7:0] idx, input [7:0] wd, output [7:0] d);
    int n;
    begin
      n = 0;
      @(posedge mclk);
      avs_address <= {idx, 2'h0};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, wd};
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 100);
      if (avs_waitrequest !== 1'b0)
      begin
        error_cnt++;
        $display("FAIL bus wait exp answer got timeout");
      end
      d = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  // Load count, run n source edges, stop, read back both bytes
  task run_ext(input [7:0] ctl, input [15:0] start, input int n, output [15:0] c);
    int s;
    int w;
    begin
      bus(1'b1, `ACNT_IDX_CONTROL, 8'h00, rd);
      bus(1'b1, `ACNT_IDX_COUNT_LOW, start[7:0], rd);
      bus(1'b1, `ACNT_IDX_COUNT_HIGH, start[15:8], rd);
      bus(1'b1, `ACNT_IDX_CONTROL, ctl, rd);
      s = edge_cnt;
      w = 0;
      src_run <= 1'b1;
      while (edge_cnt - s < n && w < 1000)
      begin
        @(posedge mclk);
        w++;
      end
      src_run <= 1'b0;
      if (edge_cnt - s < n)
      begin
        error_cnt++;
        $display("FAIL source edges exp %0d got %0d", n, edge_cnt - s);
      end
      // Room for the two-flop synchroniser to drain
      repeat (8) @(posedge mclk);
      bus(1'b1, `ACNT_IDX_CONTROL, 8'h00, rd);
      // stopped, so no carry between reads
      bus(1'b0, `ACNT_IDX_COUNT_LOW, 8'h00, c[7:0]);
      bus(1'b0, `ACNT_IDX_COUNT_HIGH, 8'h00, c[15:8]);
    end
  endtask
  // Reset values, unmapped write ignored
  task t_regs;
    reg [7:0] lst [0:4];
    begin
      lst = '{`ACNT_IDX_IRQ_CONTROL, `ACNT_IDX_IRQ_FLAGS, `ACNT_IDX_CONTROL,
        `ACNT_IDX_IRQ_ENABLES, 8'h20};
      bus(1'b1, 8'h20, 8'h5A, rd);
      foreach (lst[i])
      begin
        bus(1'b0, lst[i], 8'h00, rd);
        `CHK("reset value", 8'h00, rd)
      end
    end
  endtask
  // Every prescale code, bypass on odd codes
  task t_prescale;
    reg [15:0] c;
    begin
      for (int ps = 0; ps < 4; ps++)
      begin
        run_ext({2'h0, ps[1:0], 1'b0, ps[0], 2'h3}, 16'h0000, 24, c);
        `CHK("prescaled count", 16'h0018 >> ps, c)
      end
    end
  endtask
  // Gate high blocks counting, gate low lets it run
  task t_gate;
    reg [15:0] c;
    begin
      gate_pin <= 1'b1;
      run_ext(8'h47, 16'h0100, 8, c);
      `CHK("gated count", 16'h0100, c)
      gate_pin <= 1'b0;
      run_ext(8'h47, 16'h0100, 8, c);
      `CHK("open gate count", 16'h0108, c)
    end
  endtask
  // Internal clock: 40 counting edges between the two control writes
  task t_int;
    reg [15:0] c;
    begin
      bus(1'b1, `ACNT_IDX_COUNT_LOW, 8'h00, rd);
      bus(1'b1, `ACNT_IDX_COUNT_HIGH, 8'h00, rd);
      bus(1'b1, `ACNT_IDX_CONTROL, 8'h01, rd);
      // 37 idle edges plus three of the stop write
      repeat (37) @(posedge mclk);
      bus(1'b1, `ACNT_IDX_CONTROL, 8'h00, rd);
      bus(1'b0, `ACNT_IDX_COUNT_LOW, 8'h00, c[7:0]);
      bus(1'b0, `ACNT_IDX_COUNT_HIGH, 8'h00, c[15:8]);
      `CHK("internal count", 16'h000A, c)
    end
  endtask
  // Sleep: synchronised mode halts, bypass mode keeps counting
  task t_sleep;
    reg [15:0] c;
    begin
      sleep_mode <= 1'b1;
      run_ext(8'h03, 16'h00F0, 8, c);
      `CHK("sleep sync count", 16'h00F0, c)
      run_ext(8'h07, 16'h00FC, 8, c);
      `CHK("sleep bypass count", 16'h0104, c)
      sleep_mode <= 1'b0;
    end
  endtask
  // Rollover in sleep, mask, wake, branch, clear on read
  task t_irq;
    reg [15:0] c;
    begin
      bus(1'b1, `ACNT_IDX_IRQ_CONTROL, 8'hC0, rd);
      bus(1'b1, `ACNT_IDX_IRQ_ENABLES, 8'h00, rd);
      sleep_mode <= 1'b1;
      run_ext(8'h07, 16'hFFFF, 1, c);
      `CHK("rollover", 16'h0000, c)
      `CHK("masked irq", 1'b0, irq)
      bus(1'b1, `ACNT_IDX_IRQ_ENABLES, 8'h01, rd);
      @(negedge mclk);
      `CHK("irq wake branch", 3'h7, {irq, wake_req, isr_branch})
      bus(1'b1, `ACNT_IDX_IRQ_CONTROL, 8'h40, rd);
      @(negedge mclk);
      `CHK("wake no branch", 2'h2, {wake_req, isr_branch})
      bus(1'b0, `ACNT_IDX_IRQ_FLAGS, 8'h00, rd);
      `CHK("flag read", 8'h01, rd)
      @(negedge mclk);
      `CHK("irq cleared", 1'b0, irq)
      @(posedge mclk);
      sleep_mode <= 1'b0;
    end
  endtask
  // Oscillator enable and pin override
  task t_osc;
    begin
      sys_clk_internal <= 1'b1;
      pin_in <= 4'h3;
      bus(1'b1, `ACNT_IDX_CONTROL, 8'h08, rd);
      @(negedge mclk);
      `CHK("osc on", 5'h1C, {low_power_crystal_osc, pin4_direction, pin5_direction,
        port_pin_4, port_pin_5})
      @(posedge mclk);
      sys_clk_internal <= 1'b0;
      @(negedge mclk);
      `CHK("osc blocked", 5'h03, {low_power_crystal_osc, pin4_direction, pin5_direction,
        port_pin_4, port_pin_5})
    end
  endtask
  // Verdict and end of run
  task report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_prescale;
    t_gate;
    t_int;
    t_sleep;
    t_irq;
    t_osc;
    report_and_stop;
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    $display("FAIL watchdog exp done got timeout");
    report_and_stop;
  end
endmodule // tb_async_counter_with_lp_osc
